/* File: pkg/dsp_map.svh */
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define DSP_OFF_CTRL 8'h00
`define DSP_OFF_STATUS 8'h04
`define DSP_OFF_TRAPREG 8'h08
`define DSP_OFF_DATA 8'h0C

// Control register fields.
`define DSP_CTRL_NOMASK 0
`define DSP_CTRL_TRAP_LO 1
`define DSP_CTRL_TRAP_HI 6
`define DSP_CTRL_RESET 7'h00

// Status register fields.
`define DSP_STS_SELFCLK 0
`define DSP_STS_BUSY 1
`define DSP_STS_PEND_M 2
`define DSP_STS_PEND_NM 3
`define DSP_STS_SCAN 4

// Shift register geometry and frame lengths.
`define DSP_SR_W 35
`define DSP_LEN_TRAP 6'h0A
`define DSP_LEN_CPU 6'h23
`define DSP_TRAP_DATA_W 7

// Status bits that follow the ready bit in an outgoing word.
`define DSP_OST_DATA 2'h0
`define DSP_OST_NULL 2'h3

// Clocks after reset-out negation for mode latch and scan start.
`define DSP_MODE_LATCH_CLK 5'h08
`define DSP_SCAN_START_CLK 5'h10

// Reset values.
`define DSP_TRAPREG_RESET 9'h000
`define DSP_SR_RESET 35'h000000000

`endif

/* File: pkg/dsp_pkg.sv */
package dsp_pkg;

    // Trap-enable control register layout, nine bits.
    typedef struct packed {
        logic brk_nomask;
        logic brk_mask;
        logic sync;
        logic [5:0] trap;
    } dsp_trapreg_t;

    // Serial port sequencer states.
    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_DRAIN = 4'h2,
        ST_SCAN = 4'h4,
        ST_SHIFT = 4'h8
    } dsp_state_t;

    // Breakpoint request sources, plus the load/store-done and recoverable-state inputs from the processor.
    typedef struct packed {
        logic internal;
        logic periph;
        logic ls_done;
        logic ri;
    } dsp_brk_in_t;

endpackage

/* File: core/dsp_sync.sv */
`timescale 1ns/100ps
`include "dsp_map.svh"

// Two-flop synchroniser for one level from outside the clock domain.
module dsp_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;

    // The first flop feeds only the second, so metastability never reaches logic.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* File: core/dsp_port.sv */
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "dsp_map.svh"

// Contract
// [RQ1] Tool can request maskable or non-maskable breakpoint.
// [RQ2] Serial break bits sticky; break only on rise.
// [RQ3] External break taken after load/store instruction.
// [RQ4] Maskable break waits for recoverable-state flag.
// [RQ5] Non-maskable break ignores recoverable-state flag.
// [RQ6] Peripherals raise only maskable breaks.
// [RQ7] Recoverable flag saved with taken break.
// [RQ8] Nomask bit makes internal breaks non-maskable.
// [RQ9] Serial inputs synchronised before internal use.
// [RQ10] Shift in at LSB, new MSB out.
// [RQ11] Tool keeps serial clock at half system clock.
// [RQ12] Frames bounded by ready and start bits.
// [RQ13] Outside debug to trap register, else CPU.
// [RQ14] Serial out shows PLL lock during reset.
// [RQ15] 35-bit shift register, parallel transfer out.
// [RQ16] Debug mode fetches instructions from shift register.
// [RQ17] Move-from returns word shifted in by tool.
// [RQ18] Move-to loads shift register for shifting out.
// [RQ19] Nine-bit trap register drives traps, breaks, sync.
// [RQ20] Ready low, then start bit, then data.
// [RQ21] Length one: 7 bits; zero: 32 bits.
// [RQ22] Trap transfer ten bits, control selects target.
// [RQ23] Data-in latched eight clocks after reset-out: mode.
// [RQ24] Trap register, break requests cleared by reset.
// [RQ25] CPU-length transfer outside debug mode ignored.
module dsp_port (
    input wire logic MCLK,
    input wire logic NRST,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Serial link pins.
    input wire logic DEBUG_SERIAL_CLOCK,
    input wire logic DEBUG_SERIAL_IN,
    output logic DEBUG_SERIAL_OUT,
    input wire logic PLL_LOCK_INDICATOR,
    input wire logic RESET_OUT_SIGNAL,
    // Processor side.
    input wire logic [1:0] FREEZE_INDICATOR_PINS,
    input wire logic CPU_PDATA_READ,
    input wire logic CPU_PDATA_WRITE,
    input wire logic [31:0] CPU_PDATA_WDATA,
    output logic [31:0] CPU_PDATA_RDATA,
    output logic CPU_WORD_VALID,
    output logic CPU_WORD_IS_DATA,
    input wire dsp_pkg::dsp_brk_in_t BRK_IN,
    output logic [5:0] TRAP_ENABLE,
    output logic SYNC_OUT,
    output logic BREAK_TAKEN,
    output logic BREAK_NONMASK,
    output logic SAVED_RI
);
    logic sclk_s;
    logic din_s;
    logic pll_s;
    logic sclk_d_ff;
    dsp_pkg::dsp_state_t state_ff;
    dsp_pkg::dsp_state_t nxt_state;
    logic [`DSP_SR_W-1:0] sr_ff;
    logic [`DSP_SR_W-1:0] nxt_sr;
    logic [5:0] bit_cnt_ff;
    logic [5:0] nxt_bit_cnt;
    logic len_ff;
    logic [4:0] rst_cnt_ff;
    logic selfclk_ff;
    dsp_pkg::dsp_trapreg_t trapreg_ff;
    dsp_pkg::dsp_trapreg_t nxt_trapreg;
    logic brk_m_d_ff;
    logic brk_nm_d_ff;
    logic pend_m_ff;
    logic pend_nm_ff;
    logic [6:0] ctrl_ff;
    logic [31:0] cpu_word_ff;
    logic out_ff;
    logic cpu_valid_ff;
    logic cpu_is_data_ff;
    logic [5:0] trap_ff;
    logic sync_ff;
    logic taken_ff;
    logic nonmask_ff;
    logic saved_ri_ff;
    logic [31:0] hrdata_ff;
    logic hready_ff;
    logic dp_wr_ff;
    logic [7:0] dp_addr_ff;

    // The serial clock, data and PLL lock come from pins and are synchronised.
    dsp_sync u_sync_clk (
        .clk(MCLK),
        .rst_n(NRST),
        .din(DEBUG_SERIAL_CLOCK),
        .dout(sclk_s)
    ); // [RQ9]
    dsp_sync u_sync_din (
        .clk(MCLK),
        .rst_n(NRST),
        .din(DEBUG_SERIAL_IN),
        .dout(din_s)
    ); // [RQ9]
    dsp_sync u_sync_pll (
        .clk(MCLK),
        .rst_n(NRST),
        .din(PLL_LOCK_INDICATOR),
        .dout(pll_s)
    );

    // Shift tick: every clock in self-clocked mode, else a rise of the synced clock.
    // Edge detection needs both clock levels sampled, hence the half-rate limit.
    wire sclk_rise = sclk_s & ~sclk_d_ff; // [RQ11]
    wire tick = selfclk_ff | sclk_rise; // [RQ10]
    wire debug_mode = |FREEZE_INDICATOR_PINS;
    wire rst_done = (rst_cnt_ff == `DSP_SCAN_START_CLK);
    wire [`DSP_SR_W-1:0] sr_shift = {sr_ff[`DSP_SR_W-2:0], din_s}; // [RQ10] [RQ15]
    wire [5:0] cnt_inc = bit_cnt_ff + 6'h01;
    wire len_now = (cnt_inc == 6'h02) ? din_s : len_ff;
    wire frame_end = (state_ff == dsp_pkg::ST_SHIFT) && tick &&
        (cnt_inc == (len_now ? `DSP_LEN_TRAP : `DSP_LEN_CPU)); // [RQ21] [RQ22]
    wire trap_done = frame_end & len_now;
    wire cpu_done = frame_end & ~len_now & debug_mode; // [RQ13] [RQ25]
    wire trap_ctrl = sr_shift[`DSP_TRAP_DATA_W];
    wire [6:0] trap_data = sr_shift[`DSP_TRAP_DATA_W-1:0];

    // Frame sequencer: hold off after reset, drain a high data line, scan, shift.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_sr = sr_ff;
        nxt_bit_cnt = bit_cnt_ff;
        case (state_ff)
            dsp_pkg::ST_HOLD:
            begin
                if (rst_done)
                begin
                    nxt_state = din_s ? dsp_pkg::ST_DRAIN : dsp_pkg::ST_SCAN;
                end
            end
            dsp_pkg::ST_DRAIN:
            begin
                if (!din_s)
                begin
                    nxt_state = dsp_pkg::ST_SCAN;
                end
            end
            dsp_pkg::ST_SCAN:
            begin
                // Ready bit stays low on the output until the start bit arrives.
                if (tick && din_s) // [RQ12] [RQ20]
                begin
                    nxt_state = dsp_pkg::ST_SHIFT;
                    nxt_sr = sr_shift;
                    nxt_bit_cnt = 6'h01;
                end
            end
            dsp_pkg::ST_SHIFT:
            begin
                if (tick)
                begin
                    nxt_sr = sr_shift;
                    nxt_bit_cnt = cnt_inc;
                    if (frame_end)
                    begin
                        // Reload with a low ready bit so the next frame can begin.
                        nxt_state = dsp_pkg::ST_SCAN;
                        nxt_sr = cpu_done ? {1'b0, `DSP_OST_DATA, sr_shift[31:0]}
                            : {1'b0, `DSP_OST_NULL, 32'h00000000}; // [RQ20]
                    end
                end
            end
            default:
            begin
                nxt_state = dsp_pkg::ST_HOLD;
            end
        endcase
        // A move-to from the processor parallel-loads the word to send out.
        if (CPU_PDATA_WRITE && debug_mode && state_ff != dsp_pkg::ST_SHIFT) // [RQ18]
        begin
            nxt_sr = {1'b0, `DSP_OST_DATA, CPU_PDATA_WDATA};
        end
    end

    // Trap-enable register update; control bit picks trap/sync or break bits.
    always_comb
    begin
        nxt_trapreg = trapreg_ff;
        if (trap_done && !debug_mode) // [RQ13] [RQ19]
        begin
            if (trap_ctrl) // [RQ22]
            begin
                nxt_trapreg.brk_nomask = trap_data[6]; // [RQ1]
                nxt_trapreg.brk_mask = trap_data[5]; // [RQ1]
            end
            else
            begin
                nxt_trapreg.trap = trap_data[6:1];
                nxt_trapreg.sync = trap_data[0];
            end
        end
    end

    // Breakpoint sources; peripherals may only ask for a maskable one.
    wire nomask = ctrl_ff[`DSP_CTRL_NOMASK];
    wire serial_m_rise = trapreg_ff.brk_mask & ~brk_m_d_ff; // [RQ2]
    wire serial_nm_rise = trapreg_ff.brk_nomask & ~brk_nm_d_ff; // [RQ2]
    wire set_m = serial_m_rise | BRK_IN.periph | (BRK_IN.internal & ~nomask); // [RQ6] [RQ8]
    wire set_nm = serial_nm_rise | (BRK_IN.internal & nomask); // [RQ6] [RQ8]
    wire take_nm = BRK_IN.ls_done & pend_nm_ff; // [RQ3] [RQ5]
    wire take_m = BRK_IN.ls_done & pend_m_ff & BRK_IN.ri; // [RQ3] [RQ4]
    wire take = take_nm | take_m;

    // AHB-Lite decode; only NONSEQ/SEQ with HREADY high starts a transfer.
    wire ap_valid = HSEL & HTRANS[1] & HREADY;
    wire [31:0] status_word = {27'h0000000, state_ff == dsp_pkg::ST_SCAN, pend_nm_ff,
        pend_m_ff, state_ff == dsp_pkg::ST_SHIFT, selfclk_ff};
    wire [31:0] rd_mux = (HADDR == `DSP_OFF_CTRL) ? {25'h0000000, ctrl_ff}
        : (HADDR == `DSP_OFF_STATUS) ? status_word
        : (HADDR == `DSP_OFF_TRAPREG) ? {23'h000000, trapreg_ff}
        : (HADDR == `DSP_OFF_DATA) ? cpu_word_ff : 32'h00000000;

    // Sequencer, shift register and mode latch.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            state_ff <= dsp_pkg::ST_HOLD;
            sr_ff <= `DSP_SR_RESET;
            bit_cnt_ff <= 6'h00;
            len_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            rst_cnt_ff <= 5'h00;
            selfclk_ff <= 1'b0;
        end
        else
        begin
            state_ff <= RESET_OUT_SIGNAL ? dsp_pkg::ST_HOLD : nxt_state;
            sr_ff <= nxt_sr;
            bit_cnt_ff <= nxt_bit_cnt;
            len_ff <= len_now;
            sclk_d_ff <= sclk_s;
            if (RESET_OUT_SIGNAL)
            begin
                rst_cnt_ff <= 5'h00;
            end
            else if (!rst_done)
            begin
                rst_cnt_ff <= rst_cnt_ff + 5'h01;
            end
            if (!RESET_OUT_SIGNAL && rst_cnt_ff == `DSP_MODE_LATCH_CLK) // [RQ23]
            begin
                selfclk_ff <= din_s;
            end
        end
    end

    // Serial output: PLL lock while reset-out stands, else the new MSB.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            out_ff <= 1'b0;
        end
        else
        begin
            out_ff <= RESET_OUT_SIGNAL ? pll_s : nxt_sr[`DSP_SR_W-1]; // [RQ14] [RQ10]
        end
    end

    // Trap-enable register and CPU word handover.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            trapreg_ff <= `DSP_TRAPREG_RESET; // [RQ24]
            cpu_word_ff <= 32'h00000000;
            cpu_valid_ff <= 1'b0;
            cpu_is_data_ff <= 1'b0;
        end
        else
        begin
            trapreg_ff <= nxt_trapreg;
            cpu_valid_ff <= cpu_done; // [RQ16]
            if (cpu_done)
            begin
                cpu_word_ff <= sr_shift[31:0]; // [RQ17]
                cpu_is_data_ff <= sr_shift[32];
            end
        end
    end

    // Pending breaks: a new request in the taking cycle wins over the clear.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            brk_m_d_ff <= 1'b0;
            brk_nm_d_ff <= 1'b0;
            pend_m_ff <= 1'b0; // [RQ24]
            pend_nm_ff <= 1'b0; // [RQ24]
            taken_ff <= 1'b0;
            nonmask_ff <= 1'b0;
            saved_ri_ff <= 1'b0;
        end
        else
        begin
            brk_m_d_ff <= trapreg_ff.brk_mask;
            brk_nm_d_ff <= trapreg_ff.brk_nomask;
            pend_m_ff <= (pend_m_ff & ~take) | set_m;
            pend_nm_ff <= (pend_nm_ff & ~take) | set_nm;
            taken_ff <= take;
            nonmask_ff <= take_nm;
            if (take)
            begin
                saved_ri_ff <= BRK_IN.ri; // [RQ7]
            end
        end
    end

    // Trap enables are the OR of software and serially loaded bits.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            trap_ff <= 6'h00;
            sync_ff <= 1'b0;
        end
        else
        begin
            trap_ff <= trapreg_ff.trap | ctrl_ff[`DSP_CTRL_TRAP_HI:`DSP_CTRL_TRAP_LO]; // [RQ19]
            sync_ff <= trapreg_ff.sync; // [RQ19]
        end
    end

    // AHB-Lite slave: zero wait states, read data registered at the address phase.
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            ctrl_ff <= `DSP_CTRL_RESET;
            hrdata_ff <= 32'h00000000;
            hready_ff <= 1'b1;
            dp_wr_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
        end
        else
        begin
            hready_ff <= 1'b1;
            dp_wr_ff <= ap_valid & HWRITE;
            dp_addr_ff <= HADDR;
            if (ap_valid && !HWRITE)
            begin
                hrdata_ff <= rd_mux;
            end
            if (dp_wr_ff && dp_addr_ff == `DSP_OFF_CTRL)
            begin
                ctrl_ff <= HWDATA[6:0];
            end
        end
    end

    assign HRDATA = hrdata_ff;
    assign HREADYOUT = hready_ff;
    assign HRESP = 1'b0;
    assign DEBUG_SERIAL_OUT = out_ff;
    assign CPU_PDATA_RDATA = cpu_word_ff; // [RQ17]
    assign CPU_WORD_VALID = cpu_valid_ff;
    assign CPU_WORD_IS_DATA = cpu_is_data_ff;
    assign TRAP_ENABLE = trap_ff;
    assign SYNC_OUT = sync_ff;
    assign BREAK_TAKEN = taken_ff;
    assign BREAK_NONMASK = nonmask_ff;
    assign SAVED_RI = saved_ri_ff;

    // CPU_PDATA_READ needs no action: the word is held stable until the next frame.
    wire unused_ok = CPU_PDATA_READ ^ ^HSIZE;
endmodule

/* File: tb/dsp_port_sva.sv */
`timescale 1ns/100ps
// Watches break hand-off, reset clearing and the shared serial-out pin.
module dsp_port_sva (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic DEBUG_SERIAL_OUT,
    input wire logic PLL_LOCK_INDICATOR,
    input wire logic RESET_OUT_SIGNAL,
    input wire logic [1:0] FREEZE_INDICATOR_PINS,
    input wire logic CPU_WORD_VALID,
    input wire dsp_pkg::dsp_brk_in_t BRK_IN,
    input wire logic [5:0] TRAP_ENABLE,
    input wire logic BREAK_TAKEN,
    input wire logic BREAK_NONMASK,
    input wire logic SAVED_RI
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);
    // Reset leaves no trap enabled and no break taken.
    property p_clear;
        $rose(NRST) |-> TRAP_ENABLE == 6'h00 && !BREAK_TAKEN;
    endproperty
    a_clear: assert property (p_clear) else $error("Outputs set after reset.");
    // A break is taken one cycle after a finished load/store, never elsewhere.
    property p_take;
        BREAK_TAKEN |-> $past(BRK_IN.ls_done);
    endproperty
    a_take: assert property (p_take) else $error("Break without load/store.");
    property p_mask;
        BREAK_TAKEN && !BREAK_NONMASK |-> $past(BRK_IN.ri);
    endproperty
    a_mask: assert property (p_mask) else $error("Masked break taken.");
    // The saved flag is what lets software tell whether it can resume.
    property p_ri;
        BREAK_TAKEN |-> SAVED_RI == $past(BRK_IN.ri);
    endproperty
    a_ri: assert property (p_ri) else $error("Saved flag wrong.");
    property p_nm;
        BREAK_NONMASK |-> BREAK_TAKEN;
    endproperty
    a_nm: assert property (p_nm) else $error("Nonmask flag alone.");
    // Five samples cover the synchroniser and the output register.
    property p_pll_hi;
        (RESET_OUT_SIGNAL && PLL_LOCK_INDICATOR) [*5] |-> DEBUG_SERIAL_OUT;
    endproperty
    a_pll_hi: assert property (p_pll_hi) else $error("Lock not shown.");
    property p_pll_lo;
        (RESET_OUT_SIGNAL && !PLL_LOCK_INDICATOR) [*5] |-> !DEBUG_SERIAL_OUT;
    endproperty
    a_pll_lo: assert property (p_pll_lo) else $error("Lock loss not shown.");
    property p_word;
        CPU_WORD_VALID |-> $past(FREEZE_INDICATOR_PINS) != 2'h0;
    endproperty
    a_word: assert property (p_word) else $error("Word outside debug.");
endmodule

bind dsp_port dsp_port_sva chk_u (.MCLK, .NRST, .DEBUG_SERIAL_OUT, .PLL_LOCK_INDICATOR,
    .RESET_OUT_SIGNAL, .FREEZE_INDICATOR_PINS, .CPU_WORD_VALID, .BRK_IN, .TRAP_ENABLE,
    .BREAK_TAKEN, .BREAK_NONMASK, .SAVED_RI);

/* File: tb/dsp_tool_model.sv */
`timescale 1ns/100ps
// Development tool: drives serial clock and data, collects the out pin.
module dsp_tool_model (
    output logic sclk,
    output logic sdin,
    input wire logic sdout
);
    // Clock rests low and data at the pull-down level between frames.
    initial
    begin
        sclk = 1'h0;
        sdin = 1'h0;
    end
    // Sends n bits first bit first; edges avoid the system clock edges.
    task automatic xfer(input int n, input logic [34:0] tx, output logic [34:0] rx);
        rx = 35'h0;
        #25;
        while (sdout !== 1'h0)
            #100;
        for (int k = n - 1; k >= 0; k--)
        begin
            sdin = tx[k];
            #390;
            if (k < n - 1)
                rx = {rx[33:0], sdout};
            #10 sclk = 1'h1;
            #400 sclk = 1'h0;
        end
        #390 rx = {rx[33:0], sdout};
        sdin = 1'h0;
    endtask
    // Holds the data line at a level, off the system clock edge, for mode selection.
    task automatic level(input logic v);
        #25;
        sdin = v;
    endtask
endmodule

/* File: tb/dsp_port_tb.sv */
`timescale 1ns/100ps
`include "dsp_map.svh"
// Bench for the debug serial port: bus, serial tool and break inputs.
module dsp_port_tb;
    typedef struct packed {
        logic [6:0] d;
        logic [5:0] t;
        logic s;
    } dsp_row_t;
    logic mclk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, pll = 1'h0, mv_wr = 1'h0;
    logic rst_out = 1'h1;
    logic [1:0] htrans = 2'h0, freeze = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, mv_wdata = 32'h0;
    dsp_pkg::dsp_brk_in_t brk_in = 4'h0;
    logic hready, sclk, sdin, sdout, cpu_valid, cpu_is_data, sync_out, brk_taken, brk_nm;
    logic saved_ri;
    logic [5:0] trap_en;
    logic [31:0] hrdata, cpu_rdata, rd;
    logic [34:0] rx;
    int fail_count = 0, checks = 0, cycles = 0, vcnt = 0;
    // Trap frames with control bit clear: data sent, traps and sync expected.
    dsp_row_t rows [4] = '{'{7'h55, 6'h2A, 1'h1}, '{7'h2A, 6'h15, 1'h0},
        '{7'h7F, 6'h3F, 1'h1}, '{7'h4B, 6'h25, 1'h1}};
    dsp_port dut_u (
        .MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(), .DEBUG_SERIAL_CLOCK(sclk), .DEBUG_SERIAL_IN(sdin),
        .DEBUG_SERIAL_OUT(sdout), .PLL_LOCK_INDICATOR(pll), .RESET_OUT_SIGNAL(rst_out),
        .FREEZE_INDICATOR_PINS(freeze), .CPU_PDATA_READ(1'h0), .CPU_PDATA_WRITE(mv_wr),
        .CPU_PDATA_WDATA(mv_wdata), .CPU_PDATA_RDATA(cpu_rdata), .CPU_WORD_VALID(cpu_valid),
        .CPU_WORD_IS_DATA(cpu_is_data), .BRK_IN(brk_in), .TRAP_ENABLE(trap_en),
        .SYNC_OUT(sync_out), .BREAK_TAKEN(brk_taken), .BREAK_NONMASK(brk_nm),
        .SAVED_RI(saved_ri));
    dsp_tool_model tool_u (.sclk(sclk), .sdin(sdin), .sdout(sdout));
    // System clock at 10 MHz.
    always #50 mclk = ~mclk;
    // Counts finished words; the ceiling is well above the planned run.
    always @(posedge mclk)
    begin
        cycles++;
        if (cpu_valid === 1'h1)
            vcnt++;
        if (cycles == 8000)
        begin
            fail_count++;
            summarize();
        end
    end
    // Compares one value and reports a difference at once.
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize();
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One single-word bus transfer; read data is taken at the end of the data phase.
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'h1);
        r = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'h0, a, 32'h0, rd);
        chk(rd, e);
    endtask
    // Pulses a break source, then ends a load/store; e is taken, nonmask, saved flag.
    task brk(input logic [1:0] src, input logic ri, input logic [2:0] e);
        @(posedge mclk);
        brk_in <= {src, 1'h0, ri};
        @(posedge mclk);
        brk_in <= {2'h0, 1'h0, ri};
        repeat (3) @(posedge mclk);
        brk_in <= {2'h0, 1'h1, ri};
        chk(brk_taken, 1'h0);
        @(posedge mclk);
        brk_in <= {2'h0, 1'h0, ri};
        #1;
        chk({brk_taken, brk_nm, brk_taken & saved_ri}, e);
    endtask
    // Reset, pin sharing, registers, frames, then the break cases.
    initial
    begin
        repeat (12) @(posedge mclk);
        nrst <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(sdout, 1'h0);
        pll <= 1'h1;
        repeat (6) @(posedge mclk);
        chk(sdout, 1'h1);
        rst_out <= 1'h0;
        repeat (24) @(posedge mclk);
        chk(sdout, 1'h0);
        rchk(`DSP_OFF_CTRL, 32'h0);
        rchk(`DSP_OFF_TRAPREG, 32'h0);
        rchk(8'h10, 32'h0);
        ahb(1'h0, `DSP_OFF_STATUS, 32'h0, rd);
        chk(rd[0], 1'h0);
        ahb(1'h1, `DSP_OFF_CTRL, 32'h7F, rd);
        rchk(`DSP_OFF_CTRL, 32'h7F);
        chk(trap_en, 6'h3F);
        ahb(1'h1, `DSP_OFF_CTRL, 32'h0, rd);
        foreach (rows[i])
        begin
            tool_u.xfer(10, {25'h0, 3'h6, rows[i].d}, rx);
            repeat (4) @(posedge mclk);
            chk({trap_en, sync_out}, {rows[i].t, rows[i].s});
            rchk(`DSP_OFF_TRAPREG, {25'h0, rows[i].s, rows[i].t});
        end
        tool_u.xfer(35, {3'h4, 32'hDEADBEEF}, rx);
        repeat (4) @(posedge mclk);
        chk({trap_en, vcnt}, {6'h25, 32'h0});
        freeze <= 2'h1;
        tool_u.xfer(35, {3'h5, 32'hA5C30F96}, rx);
        repeat (4) @(posedge mclk);
        chk(rx[34:33], 2'h3);
        chk({cpu_is_data, cpu_rdata}, {1'h1, 32'hA5C30F96});
        rchk(`DSP_OFF_DATA, 32'hA5C30F96);
        tool_u.xfer(35, {3'h4, 32'h0}, rx);
        repeat (4) @(posedge mclk);
        chk({vcnt, cpu_is_data, rx[32:1]}, {32'h2, 1'h0, 32'hA5C30F96});
        mv_wr <= 1'h1;
        mv_wdata <= 32'h3C5A9617;
        @(posedge mclk);
        mv_wr <= 1'h0;
        tool_u.xfer(35, {3'h4, 32'h0}, rx);
        chk(rx[34:1], {2'h0, 32'h3C5A9617});
        freeze <= 2'h0;
        tool_u.xfer(10, {25'h0, 3'h7, 7'h20}, rx);
        brk(2'h0, 1'h0, 3'h0);
        brk(2'h0, 1'h1, 3'h5);
        brk(2'h0, 1'h1, 3'h0);
        tool_u.xfer(10, {25'h0, 3'h7, 7'h00}, rx);
        tool_u.xfer(10, {25'h0, 3'h7, 7'h40}, rx);
        brk(2'h0, 1'h0, 3'h6);
        brk(2'h1, 1'h0, 3'h0);
        brk(2'h0, 1'h1, 3'h5);
        ahb(1'h1, `DSP_OFF_CTRL, 32'h1, rd);
        brk(2'h2, 1'h0, 3'h6);
        ahb(1'h1, `DSP_OFF_CTRL, 32'h0, rd);
        brk(2'h2, 1'h0, 3'h0);
        brk(2'h0, 1'h1, 3'h5);
        // Second reset in mid-run with data-in high: state clears, self-clocking is chosen.
        rst_out <= 1'h1;
        nrst <= 1'h0;
        tool_u.level(1'h1);
        repeat (3) @(posedge mclk);
        nrst <= 1'h1;
        @(posedge mclk);
        chk(trap_en, 6'h00);
        rchk(`DSP_OFF_TRAPREG, 32'h0);
        rst_out <= 1'h0;
        repeat (24) @(posedge mclk);
        rchk(`DSP_OFF_STATUS, 32'h1);
        tool_u.level(1'h0);
        repeat (4) @(posedge mclk);
        rchk(`DSP_OFF_STATUS, 32'h11);
        summarize();
    end
endmodule
